// [ilim_clamp.sv]
`timescale 1ns/10ps
// ****************************************************************
// Output current clamp
// ****************************************************************
module ilim_clamp
#(
    parameter int W = 16
)
(
    // Command and limit
    input  wire logic [W-1:0] cmd,
    input  wire logic [W-1:0] cont,
    input  wire logic         limit,
    // Selected current
    output logic      [W-1:0] sel
);

    // Clamp only while limiting and command above limit
    assign sel = (limit && (cmd > cont)) ? cont : cmd;

endmodule

// [ilim_limiter.sv]
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/10ps
// Operation
// - Setpoint is (peak^2 - cont^2) times time limit
// - Accumulator updates once per current sample
// - New value adds measured^2 minus cont^2
// - Rises above continuous limit, falls below
// - Accumulator saturates at zero, never negative
// - Reset clears the accumulator to zero
// - Limiting active in clamp mode while accumulator exceeds setpoint
// - Limiting and command above: output continuous limit
// - Limiting and command not above: pass command
// - Overload handled by clamp or by fault
module ilim_limiter
#(
    parameter int IW = 16,
    parameter int TW = 16
)
(
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // Current loop side
    input  wire logic          sample_valid,
    input  wire logic [IW-1:0] cmd_current,
    input  wire logic [IW-1:0] meas_current,
    output logic      [IW-1:0] out_current,
    output logic               limit_active,
    output logic               fault
);

    localparam int SW = 2 * IW;
    localparam int AW = SW + TW;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic              fault_mode;
    logic [IW-1:0]     peak_lim;
    logic [IW-1:0]     cont_lim;
    logic [TW-1:0]     time_lim;
    logic [AW-1:0]     acc;
    logic [AW-1:0]     setpoint;
    logic [AW-1:0]     next_setpoint;
    logic [AW-1:0]     next_acc;
    logic [SW-1:0]     peak_sq;
    logic [SW-1:0]     cont_sq;
    logic [SW-1:0]     meas_sq;
    logic signed [SW:0]   delta;
    logic signed [AW+1:0] sum;
    logic              over;
    logic              wr_en;
    logic              rd_setup;
    logic              addr_ok;
    logic              fault_clr;
    logic [31:0]       rd_val;
    logic [IW-1:0]     clamp_sel;

    // ****************************************************************
    // Squares of the limits and the measured current
    // ****************************************************************
    ilim_square #(.W(IW)) u_sq_peak
    (
        .a  (peak_lim),
        .sq (peak_sq)
    );

    ilim_square #(.W(IW)) u_sq_cont
    (
        .a  (cont_lim),
        .sq (cont_sq)
    );

    ilim_square #(.W(IW)) u_sq_meas
    (
        .a  (meas_current),
        .sq (meas_sq)
    );

    // ****************************************************************
    // APB decode
    // ****************************************************************
    // Known word addresses
    always_comb
    begin
        case (paddr)
            ilim_pkg::OFS_CTRL,
            ilim_pkg::OFS_PEAK,
            ilim_pkg::OFS_CONT,
            ilim_pkg::OFS_TLIM,
            ilim_pkg::OFS_STATUS,
            ilim_pkg::OFS_ACC_LO,
            ilim_pkg::OFS_ACC_HI,
            ilim_pkg::OFS_SET_LO,
            ilim_pkg::OFS_SET_HI: addr_ok = 1'b1;
            default:              addr_ok = 1'b0;
        endcase
    end

    // Zero wait states; error only on unmapped access
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !addr_ok;
    assign wr_en     = psel && penable && pwrite && addr_ok;
    assign rd_setup  = psel && !penable && !pwrite;
    assign fault_clr = wr_en && (paddr == ilim_pkg::OFS_STATUS)
                       && pwdata[ilim_pkg::BIT_FAULT];

    // Read multiplexer
    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (paddr)
            ilim_pkg::OFS_CTRL:
                rd_val[ilim_pkg::BIT_FAULT_MODE] = fault_mode;
            ilim_pkg::OFS_PEAK:   rd_val[IW-1:0] = peak_lim;
            ilim_pkg::OFS_CONT:   rd_val[IW-1:0] = cont_lim;
            ilim_pkg::OFS_TLIM:   rd_val[TW-1:0] = time_lim;
            ilim_pkg::OFS_STATUS:
            begin
                rd_val[ilim_pkg::BIT_LIMITING] = limit_active;
                rd_val[ilim_pkg::BIT_FAULT]    = fault;
            end
            ilim_pkg::OFS_ACC_LO: rd_val = acc[31:0];
            ilim_pkg::OFS_ACC_HI: rd_val[AW-33:0] = acc[AW-1:32];
            ilim_pkg::OFS_SET_LO: rd_val = setpoint[31:0];
            ilim_pkg::OFS_SET_HI: rd_val[AW-33:0] = setpoint[AW-1:32];
            default:              rd_val = 32'h0000_0000;
        endcase
    end

    // Read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_setup)
            prdata <= rd_val;
    end

    // ****************************************************************
    // Programmed limits
    // ****************************************************************
    // Configuration writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault_mode <= 1'b0;
            peak_lim   <= ilim_pkg::RST_PEAK[IW-1:0];
            cont_lim   <= ilim_pkg::RST_CONT[IW-1:0];
            time_lim   <= ilim_pkg::RST_TLIM[TW-1:0];
        end
        else if (wr_en)
        begin
            case (paddr)
                ilim_pkg::OFS_CTRL:
                    fault_mode <= pwdata[ilim_pkg::BIT_FAULT_MODE];
                ilim_pkg::OFS_PEAK: peak_lim <= pwdata[IW-1:0];
                ilim_pkg::OFS_CONT: cont_lim <= pwdata[IW-1:0];
                ilim_pkg::OFS_TLIM: time_lim <= pwdata[TW-1:0];
                default:            fault_mode <= fault_mode;
            endcase
        end
    end

    // ****************************************************************
    // Setpoint
    // ****************************************************************
    // Peak below continuous gives a zero setpoint
    always_comb
    begin
        if (peak_sq >= cont_sq)
            next_setpoint = AW'(peak_sq - cont_sq) * AW'(time_lim);
        else
            next_setpoint = '0;
    end

    // Setpoint register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            setpoint <= '0;
        else
            setpoint <= next_setpoint;
    end

    // ****************************************************************
    // Accumulator
    // ****************************************************************
    // Signed step and sum, one sample period per unit
    assign delta = $signed({1'b0, meas_sq}) - $signed({1'b0, cont_sq});
    assign sum   = $signed({2'b00, acc}) + (AW+2)'(delta);

    // Saturate at zero below and at full scale above
    always_comb
    begin
        if (sum < 0)
            next_acc = '0;
        else if (sum[AW])
            next_acc = '1;
        else
            next_acc = sum[AW-1:0];
    end

    // Update only on a current sample
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            acc <= '0;
        else if (sample_valid)
            acc <= next_acc;
    end

    // ****************************************************************
    // Comparison and protective action
    // ****************************************************************
    // Overload when accumulator above setpoint
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            over <= 1'b0;
        else
            over <= (acc > setpoint);
    end

    // Clamp mode drives limiting
    assign limit_active = over && !fault_mode;

    // Fault mode latches a sticky fault, set beats clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fault <= 1'b0;
        else if (over && fault_mode)
            fault <= 1'b1;
        else if (fault_clr)
            fault <= 1'b0;
    end

    // Output current selection
    ilim_clamp #(.W(IW)) u_clamp
    (
        .cmd   (cmd_current),
        .cont  (cont_lim),
        .limit (limit_active),
        .sel   (clamp_sel)
    );

    // Registered output current
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_current <= '0;
        else
            out_current <= clamp_sel;
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Setpoint follows the limits one cycle later
    property p_setpoint;
        (peak_sq >= cont_sq)
            |=> setpoint == $past(AW'(peak_sq - cont_sq) * AW'(time_lim));
    endproperty
    a_setpoint: assert property (p_setpoint)
        else $error("setpoint not peak^2 - cont^2 times time limit");

    // Accumulator still between samples
    property p_hold;
        !sample_valid |=> $stable(acc);
    endproperty
    a_hold: assert property (p_hold)
        else $error("accumulator changed without a sample");

    // Unsaturated step adds the difference of squares
    property p_step;
        (sample_valid && sum >= 0 && !sum[AW])
            |=> acc == $past(acc) + $past(AW'(delta));
    endproperty
    a_step: assert property (p_step)
        else $error("accumulator step wrong");

    // Above the limit the accumulator grows
    property p_rise;
        (sample_valid && meas_current > cont_lim && acc != '1) |=> acc > $past(acc);
    endproperty
    a_rise: assert property (p_rise)
        else $error("accumulator did not rise");

    // Underflow clamps to zero
    property p_floor;
        (sample_valid && sum < 0) |=> acc == '0;
    endproperty
    a_floor: assert property (p_floor)
        else $error("accumulator went below zero");

    // Accumulator zero on reset release
    property p_reset_zero;
        $rose(presetn) |-> acc == '0;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("accumulator not cleared by reset");

    // Limiting tied to the comparison in clamp mode
    property p_limit;
        !fault_mode ##1 !fault_mode |-> limit_active == $past(acc > setpoint);
    endproperty
    a_limit: assert property (p_limit)
        else $error("limiting does not track comparison");

    // Clamped output equals continuous limit
    property p_clamp;
        (limit_active && cmd_current > cont_lim) |=> out_current == $past(cont_lim);
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("output not clamped to continuous limit");

    // Low command passes through
    property p_pass;
        (cmd_current <= cont_lim) |=> out_current == $past(cmd_current);
    endproperty
    a_pass: assert property (p_pass)
        else $error("command not passed through");

    // Fault mode never clamps
    property p_mode;
        fault_mode |-> !limit_active;
    endproperty
    a_mode: assert property (p_mode)
        else $error("clamping while in fault mode");

    // Fault raised within one cycle of overload, then sticky
    property p_fault_sticky;
        (fault && !fault_clr) |=> fault;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky)
        else $error("fault dropped without a clear");

    property p_fault_set;
        (over && fault_mode) |=> fault;
    endproperty
    a_fault_set: assert property (p_fault_set)
        else $error("fault not raised on overload");

    // Main scenarios
    c_limit: cover property (!limit_active ##1 limit_active);
    c_fault: cover property (!fault ##1 fault);
    c_floor: cover property (sample_valid && sum < 0);
    c_clear: cover property (fault ##1 !fault);

endmodule

// [ilim_loop_model.sv]
`timescale 1ns/10ps
// ****
// Current loop model
// ****
module ilim_loop_model
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Bench control
    input  wire logic        run,
    input  wire logic [3:0]  gap,
    input  wire logic [15:0] cmd_in,
    input  wire logic [15:0] meas_in,
    // Limiter side
    output logic             sample_valid,
    output logic      [15:0] cmd_current,
    output logic      [15:0] meas_current
);
    logic [3:0] wait_cnt;

    // One sample pulse every gap+1 cycles while running
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sample_valid <= 1'b0;
            wait_cnt     <= 4'h0;
        end
        else if (run && wait_cnt == 4'h0)
        begin
            sample_valid <= 1'b1;
            wait_cnt     <= gap;
        end
        else
        begin
            sample_valid <= 1'b0;
            wait_cnt     <= (wait_cnt == 4'h0) ? 4'h0 : wait_cnt - 4'h1;
        end
    end

    // Measurement valid only with a pulse, scrambled between
    assign meas_current = sample_valid ? meas_in : ~meas_in;
    assign cmd_current  = cmd_in;
endmodule

// [ilim_pkg.sv]
// ****************************************************************
// Shared constants of the current limiter
// ****************************************************************
package ilim_pkg;

    // Register byte offsets
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_PEAK   = 12'h004;
    localparam logic [11:0] OFS_CONT   = 12'h008;
    localparam logic [11:0] OFS_TLIM   = 12'h00C;
    localparam logic [11:0] OFS_STATUS = 12'h010;
    localparam logic [11:0] OFS_ACC_LO = 12'h014;
    localparam logic [11:0] OFS_ACC_HI = 12'h018;
    localparam logic [11:0] OFS_SET_LO = 12'h01C;
    localparam logic [11:0] OFS_SET_HI = 12'h020;

    // Field positions
    localparam int BIT_FAULT_MODE = 0;
    localparam int BIT_LIMITING   = 0;
    localparam int BIT_FAULT      = 1;

    // Reset values
    localparam logic [15:0] RST_PEAK = 16'h0000;
    localparam logic [15:0] RST_CONT = 16'h0000;
    localparam logic [15:0] RST_TLIM = 16'h0000;

endpackage

// [ilim_square.sv]
`timescale 1ns/10ps
// ****************************************************************
// Unsigned squarer
// ****************************************************************
module ilim_square
#(
    parameter int W = 16
)
(
    // Operand and result
    input  wire logic [W-1:0]   a,
    output logic      [2*W-1:0] sq
);

    // Full-width product, no truncation
    assign sq = a * a;

endmodule

// [tb.sv]
`timescale 1ns/10ps
// ****
// Current limiter testbench
// ****
module tb;
    localparam logic [47:0] ZERO = 48'h0000_0000_0000;
    localparam logic [47:0] ONE  = 48'h0000_0000_0001;
    localparam longint      CONT = 6;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        sample_valid, limit_active, fault, run;
    logic [3:0]  gap;
    logic [15:0] cmd_in, meas_in, cmd_current, meas_current, out_current;
    logic [47:0] acc_exp, v;
    int          miscompares, samples_checked;
    int          nsmp = 0;

    // Design and loop model
    ilim_limiter u_ilim_limiter (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
        .cmd_current(cmd_current), .meas_current(meas_current), .out_current(out_current),
        .limit_active(limit_active), .fault(fault));
    ilim_loop_model u_ilim_loop_model (.pclk(pclk), .presetn(presetn), .run(run),
        .gap(gap), .cmd_in(cmd_in), .meas_in(meas_in), .sample_valid(sample_valid),
        .cmd_current(cmd_current), .meas_current(meas_current));

    // Clock
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Sample pulse counter
    always @(posedge pclk)
    begin
        nsmp <= nsmp + ((sample_valid === 1'b1) ? 1 : 0);
    end

    task automatic final_report;
        $display("Compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // APB transfer, waits for pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16)
        begin
            miscompares++;
            $display("Error at %0t: pready %h expected %h", $time, pready, 1'b1);
            final_report();
        end
    endtask

    task automatic rd48(input logic [11:0] a);
        apb(1'b0, a, '0);
        v[31:0] = rd;
        apb(1'b0, a + 12'h004, '0);
        v[47:32] = rd[15:0];
    endtask

    // Run k samples, then update the expected accumulator
    task automatic feed(input logic [15:0] m, input logic [15:0] c, input int k,
                        input logic [3:0] g);
        int     s;
        int     n;
        longint a;
        s = nsmp;
        n = 0;
        meas_in <= m;
        cmd_in <= c;
        gap <= g;
        run <= 1'b1;
        while (nsmp - s < k && n < 200)
        begin
            @(posedge pclk);
            n++;
        end
        run <= 1'b0;
        repeat (6) @(posedge pclk);
        a = longint'(acc_exp) + longint'(nsmp - s) * (longint'(m) * longint'(m) - CONT * CONT);
        acc_exp = (a < 0) ? ZERO : a[47:0];
        if (n >= 200)
        begin
            miscompares++;
            $display("Error at %0t: samples %h expected %h", $time, nsmp - s, k);
            final_report();
        end
    endtask

    task automatic t_reset;
        rd48(ilim_pkg::OFS_ACC_LO);
        chk(v, ZERO);
        apb(1'b0, 12'h040, '0);
        chk(48'({err, rd}), 48'h0001_0000_0000);
        chk(48'({limit_active, fault, out_current}), ZERO);
        $display("t_reset done");
    endtask

    task automatic t_setpoint;
        // Wide product first, must not be cut to 32 bits
        apb(1'b1, ilim_pkg::OFS_PEAK, 32'h0000_1000);
        apb(1'b1, ilim_pkg::OFS_CONT, 32'h0000_0006);
        apb(1'b1, ilim_pkg::OFS_TLIM, 32'h0000_1000);
        rd48(ilim_pkg::OFS_SET_LO);
        chk(v, 48'h000F_FFFD_C000);
        apb(1'b1, ilim_pkg::OFS_PEAK, 32'h0000_000C);
        apb(1'b1, ilim_pkg::OFS_TLIM, 32'h0000_0003);
        rd48(ilim_pkg::OFS_SET_LO);
        chk(v, 48'h0000_0000_0144);
        $display("t_setpoint done");
    endtask

    task automatic t_accum;
        feed(16'h0008, 16'h0008, 3, 4'h2);
        rd48(ilim_pkg::OFS_ACC_LO);
        chk(v, acc_exp);
        chk(48'(limit_active), ZERO);
        feed(16'h0003, 16'h0003, 10, 4'h0);
        rd48(ilim_pkg::OFS_ACC_LO);
        chk(v, acc_exp);
        $display("t_accum done");
    endtask

    task automatic t_clamp;
        apb(1'b1, ilim_pkg::OFS_CTRL, '0);
        feed(16'h000C, 16'h000C, 4, 4'h1);
        rd48(ilim_pkg::OFS_ACC_LO);
        chk(v, acc_exp);
        chk(48'(limit_active), ONE);
        chk(48'(out_current), 48'h0000_0000_0006);
        feed(16'h0004, 16'h0004, 2, 4'h1);
        chk(48'(out_current), 48'h0000_0000_0004);
        feed('0, '0, 20, 4'h0);
        chk(48'(limit_active), ZERO);
        $display("t_clamp done");
    endtask

    task automatic t_fault;
        apb(1'b1, ilim_pkg::OFS_CTRL, 32'h0000_0001);
        feed(16'h000C, 16'h000C, 4, 4'h0);
        chk(48'({limit_active, fault}), ONE);
        chk(48'(out_current), 48'h0000_0000_000C);
        apb(1'b0, ilim_pkg::OFS_STATUS, '0);
        chk(48'(rd), 48'h0000_0000_0002);
        feed('0, '0, 20, 4'h0);
        chk(48'(fault), ONE);
        apb(1'b1, ilim_pkg::OFS_STATUS, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        chk(48'(fault), ZERO);
        $display("t_fault done");
    endtask

    task automatic t_rerst;
        feed(16'h0009, 16'h0009, 3, 4'h0);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        acc_exp = ZERO;
        rd48(ilim_pkg::OFS_ACC_LO);
        chk(v, ZERO);
        $display("t_rerst done");
    endtask

    // Main sequence
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, run, err} = '0;
        {paddr, pwdata, gap, cmd_in, meas_in, acc_exp} = '0;
        miscompares = 0;
        samples_checked = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_setpoint();
        t_accum();
        t_clamp();
        t_fault();
        t_rerst();
        final_report();
    end
endmodule
